// >>> rtl/lps_pkg.sv
// Constants, register map and state codes for the two-phase start-up
// and protection controller.
// Assumes a 125 MHz core clock.
package lps_pkg;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TICK_KHZ = 50;
  localparam int TICK_CYC = CLK_MHZ * 1000 / TICK_KHZ;
  localparam int PRE_ON_US = 20;
  localparam int PRE_ON_CYC = PRE_ON_US * CLK_MHZ;
  localparam int PRE_OFF_US = 100;
  localparam int PRE_OFF_CYC = PRE_OFF_US * CLK_MHZ;
  localparam int START_US = 100;
  localparam int START_CYC = START_US * CLK_MHZ;
  localparam int ZC_DLY_NS = 200;
  localparam int ZC_DLY_CYC = (ZC_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_NS = 200;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int HP_DEF_KHZ = 100;
  localparam int HP_DEF_CYC = CLK_MHZ * 1000 / (2 * HP_DEF_KHZ);
  localparam int HP_MIN_CYC = 4 * DEAD_CYC;
  localparam int RESTART_MS = 2000;
  localparam int RESTART_TICKS = RESTART_MS * TICK_KHZ;
  localparam int SLOW_MS = 40;
  localparam int SLOW_TICKS = SLOW_MS * TICK_KHZ;
  localparam int LIMIT_MS = 2000;
  localparam int LIMIT_TICKS = LIMIT_MS * TICK_KHZ;
  localparam int CAP_TRIES_DEF = 4;
  // --------------------------------------------------------------------
  // Current levels, 0.01 A per count
  // --------------------------------------------------------------------
  localparam int CUR_PER_A = 100;
  localparam int FAST_A = 50;
  localparam int SLOW_A = 35;
  localparam int LIMIT_A = 30;
  localparam int RES_A = 40;
  localparam logic [15:0] FAST_LIM = 16'(FAST_A * CUR_PER_A);
  localparam logic [15:0] SLOW_LIM = 16'(SLOW_A * CUR_PER_A);
  localparam logic [15:0] LIMIT_LIM = 16'(LIMIT_A * CUR_PER_A);
  localparam logic [15:0] RES_LIM = 16'(RES_A * CUR_PER_A);
  localparam logic [15:0] VREF_STEP = 16'h0002;
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VTGT = 8'h04;
  localparam logic [7:0] OFS_SHON = 8'h08;
  localparam logic [7:0] OFS_SHOFF = 8'h0c;
  localparam logic [7:0] OFS_JUMP = 8'h10;
  localparam logic [7:0] OFS_PTHR = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_FLT = 8'h1c;
  localparam logic [7:0] OFS_PH0 = 8'h20;
  localparam logic [7:0] OFS_PH1 = 8'h24;
  localparam logic [7:0] OFS_VREF = 8'h28;
  localparam int C_RUN = 0;
  localparam int C_LATCH = 1;
  localparam int C_SR = 2;
  localparam int C_CLR = 3;
  localparam int FB_FAST = 0;
  localparam int FB_SLOW = 1;
  localparam int FB_LIM = 2;
  localparam int FB_CAP = 3;
  localparam int FB_PREV = 4;
  localparam int FB_INOC = 5;
  localparam int FB_OT = 6;
  localparam int NFLT = 7;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] VTGT_RST = 16'h1518;
  localparam logic [15:0] SHON_RST = 16'h0fa0;
  localparam logic [15:0] SHOFF_RST = 16'h0bb8;
  localparam logic [15:0] JUMP_RST = 16'h03e8;
  localparam logic [15:0] PTHR_RST = 16'h0019;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_PRE_ON = 3'b001,
    SQ_PRE_OFF = 3'b010,
    SQ_CMP = 3'b011,
    SQ_RUN = 3'b100
  } lps_seq_t;
endpackage

// >>> rtl/lps_ctrl.sv
// Two-phase resonant half-bridge controller: start sequence, second
// phase enable, capacitive mode guard and overcurrent protection.
// Assumes current samples come from on-chip converters on core_clk and
// zero-crossing comparators arrive as raw pins.
`timescale 1ns/10ps
`default_nettype none
module lps_ctrl #(
  parameter int PRE_OFF_CYC = lps_pkg::PRE_OFF_CYC,
  parameter int START_CYC = lps_pkg::START_CYC,
  parameter int RESTART_TICKS = lps_pkg::RESTART_TICKS,
  parameter int SLOW_TICKS = lps_pkg::SLOW_TICKS,
  parameter int LIMIT_TICKS = lps_pkg::LIMIT_TICKS,
  parameter int CAP_TRIES = lps_pkg::CAP_TRIES_DEF
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Power stage sense
  input wire logic [1:0] zc_pos,
  input wire logic [15:0] i_out0,
  input wire logic [15:0] i_out1,
  input wire logic [15:0] res_cur0,
  input wire logic [15:0] res_cur1,
  input wire logic [1:0] res_valid,
  input wire logic ot_trip,
  // Power stage drive
  output logic [1:0] low_side_switch,
  output logic [1:0] high_side_switch,
  output logic [1:0] sync_rectifier,
  output logic [1:0] res_sample,
  output logic [15:0] vref,
  output logic bal_to_second
);
  typedef struct packed {
    lps_pkg::lps_seq_t [1:0] seq;
    logic [1:0][31:0] tmr;
    logic [1:0] hs, ls, sr, samp, side, pend, z1, z2, z3;
    logic [1:0][15:0] zcc, hp, dly, phc;
    logic [1:0][16:0] ph;
    logic [1:0][1:0] capz;
    logic [1:0][7:0] tries;
    logic [1:0][31:0] slow;
    logic [31:0] lim, rcnt, tick;
    logic ss_done, want2, bal;
    logic [15:0] vref;
    logic [16:0] tot_prev;
    logic [lps_pkg::NFLT-1:0] faults;
    logic [2:0] ctrl;
    logic [15:0] vtgt, shon, shoff, jump, pthr;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } lps_state_t;

  function automatic lps_state_t rst_val();
    lps_state_t s;
    s = '0;
    s.ctrl = lps_pkg::CTRL_RST;
    s.vtgt = lps_pkg::VTGT_RST;
    s.shon = lps_pkg::SHON_RST;
    s.shoff = lps_pkg::SHOFF_RST;
    s.jump = lps_pkg::JUMP_RST;
    s.pthr = lps_pkg::PTHR_RST;
    return s;
  endfunction

  localparam lps_state_t ST_RST = rst_val();

  function automatic logic is_map(input logic [7:0] a);
    case (a)
      lps_pkg::OFS_CTRL, lps_pkg::OFS_VTGT, lps_pkg::OFS_SHON,
      lps_pkg::OFS_SHOFF, lps_pkg::OFS_JUMP, lps_pkg::OFS_PTHR,
      lps_pkg::OFS_STAT, lps_pkg::OFS_FLT, lps_pkg::OFS_PH0,
      lps_pkg::OFS_PH1, lps_pkg::OFS_VREF: is_map = 1'b1;
      default: is_map = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  lps_state_t q, d;
  logic [1:0][15:0] cur, res;
  assign cur = {i_out1, i_out0};
  assign res = {res_cur1, res_cur0};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic tick_now, fault_on, two_on, go, keep, edge_z, rise_z, wr, clr;
    logic prev_act, lim_act;
    logic [lps_pkg::NFLT-1:0] fset;
    logic [16:0] tot;
    logic [15:0] mon, mag;
    logic [31:0] wm;
    d = q;
    fset = '0;
    prev_act = 1'b0;
    clr = 1'b0;
    wm = '0;
    go = 1'b0;
    keep = 1'b0;
    edge_z = 1'b0;
    rise_z = 1'b0;
    wr = 1'b0;
    lim_act = 1'b0;
    tot = '0;
    mon = '0;
    mag = '0;
    d.samp = '0;
    tick_now = (q.tick == 32'(lps_pkg::TICK_CYC - 1));
    d.tick = tick_now ? 32'd0 : q.tick + 32'd1;
    fault_on = |q.faults;
    two_on = (q.seq[0] == lps_pkg::SQ_RUN) && (q.seq[1] == lps_pkg::SQ_RUN);
    for (int p = 0; p < 2; p++) begin
      d.z1[p] = zc_pos[p];
      d.z2[p] = q.z1[p];
      d.z3[p] = q.z2[p];
      edge_z = q.z2[p] ^ q.z3[p];
      rise_z = q.z2[p] & ~q.z3[p];
      // Phase two only follows a running phase one
      go = (p == 0) ? q.ctrl[lps_pkg::C_RUN]
                    : (q.seq[0] == lps_pkg::SQ_RUN) && q.want2;
      keep = (p == 0) ? q.ctrl[lps_pkg::C_RUN]
                      : (q.seq[0] != lps_pkg::SQ_IDLE) && q.want2;
      if (fault_on || !keep) begin
        d.seq[p] = lps_pkg::SQ_IDLE;
        d.hs[p] = 1'b0;
        d.ls[p] = 1'b0;
        d.sr[p] = 1'b0;
        d.tries[p] = '0;
        d.capz[p] = '0;
        d.slow[p] = '0;
      end else begin
        case (q.seq[p])
          lps_pkg::SQ_IDLE: begin
            d.hs[p] = 1'b0;
            d.ls[p] = 1'b0;
            d.sr[p] = 1'b0;
            if (go) begin
              d.seq[p] = lps_pkg::SQ_PRE_ON;
              d.tmr[p] = '0;
              d.ls[p] = 1'b1;
            end
          end
          lps_pkg::SQ_PRE_ON: begin
            d.tmr[p] = q.tmr[p] + 32'd1;
            if (q.tmr[p] + 32'd1 >= 32'(lps_pkg::PRE_ON_CYC)) begin
              d.seq[p] = lps_pkg::SQ_PRE_OFF;
              d.ls[p] = 1'b0;
              d.tmr[p] = '0;
            end
          end
          lps_pkg::SQ_PRE_OFF: begin
            d.tmr[p] = q.tmr[p] + 32'd1;
            if (q.tmr[p] + 32'd1 >= 32'(PRE_OFF_CYC)) begin
              d.seq[p] = lps_pkg::SQ_CMP;
              d.tmr[p] = '0;
              d.zcc[p] = '0;
              d.pend[p] = 1'b0;
              d.hp[p] = 16'(lps_pkg::HP_DEF_CYC);
              d.hs[p] = 1'b1;
            end
          end
          lps_pkg::SQ_CMP: begin
            d.tmr[p] = q.tmr[p] + 32'd1;
            d.zcc[p] = (&q.zcc[p]) ? q.zcc[p] : q.zcc[p] + 16'd1;
            if (edge_z) begin
              // Both off, then follow the new current sign after a delay
              d.hs[p] = 1'b0;
              d.ls[p] = 1'b0;
              d.pend[p] = 1'b1;
              d.dly[p] = '0;
              d.zcc[p] = '0;
              if (q.zcc[p] >= 16'(lps_pkg::HP_MIN_CYC)) begin
                d.hp[p] = q.zcc[p];
              end
            end else if (q.pend[p]) begin
              d.dly[p] = q.dly[p] + 16'd1;
              if (q.dly[p] + 16'd1 >= 16'(lps_pkg::ZC_DLY_CYC)) begin
                d.hs[p] = q.z2[p];
                d.ls[p] = ~q.z2[p];
                d.pend[p] = 1'b0;
              end
            end
            if (q.tmr[p] + 32'd1 >= 32'(START_CYC)) begin
              d.seq[p] = lps_pkg::SQ_RUN;
              d.tmr[p] = '0;
              d.side[p] = ~q.z2[p];
              d.phc[p] = '0;
              d.ph[p] = {1'b0, q.hp[p]};
            end
          end
          lps_pkg::SQ_RUN: begin
            // Replica timer: half period from the captured interval
            d.tmr[p] = q.tmr[p] + 32'd1;
            d.phc[p] = (&q.phc[p]) ? q.phc[p] : q.phc[p] + 16'd1;
            if (q.tmr[p] + 32'd1 >= 32'(q.hp[p])) begin
              d.tmr[p] = '0;
              d.side[p] = ~q.side[p];
              if (q.side[p]) begin
                d.phc[p] = '0;
              end
            end
            d.hs[p] = d.side[p] && (d.tmr[p] >= 32'(lps_pkg::DEAD_CYC));
            d.ls[p] = !d.side[p] && (d.tmr[p] >= 32'(lps_pkg::DEAD_CYC));
            d.samp[p] = (q.tmr[p] == 32'(q.hp[p] >> 1));
            d.sr[p] = q.ctrl[lps_pkg::C_SR] && q.ss_done;
            if (rise_z) begin
              d.ph[p] = {1'b0, q.phc[p]} - {1'b0, q.hp[p]};
            end
            if (tick_now) begin
              if (q.ss_done && cur[p] > lps_pkg::FAST_LIM) begin
                fset[lps_pkg::FB_FAST] = 1'b1;
              end
              d.slow[p] = (cur[p] > lps_pkg::SLOW_LIM) ? q.slow[p] + 32'd1
                                                       : 32'd0;
              if (d.slow[p] >= 32'(SLOW_TICKS)) begin
                fset[lps_pkg::FB_SLOW] = 1'b1;
              end
              if ($signed(q.ph[p]) <= 17'sd0) begin
                d.capz[p] = q.capz[p] + 2'd1;
                if (q.capz[p] != 2'd0) begin
                  fset[lps_pkg::FB_CAP] = 1'b1;
                end
              end else begin
                d.capz[p] = '0;
              end
              if ($signed(q.ph[p]) < $signed({1'b0, q.pthr})) begin
                prev_act = 1'b1;
                d.tries[p] = (&q.tries[p]) ? q.tries[p]
                                           : q.tries[p] + 8'd1;
                if (d.tries[p] >= 8'(CAP_TRIES)) begin
                  fset[lps_pkg::FB_PREV] = 1'b1;
                end
              end else begin
                d.tries[p] = '0;
              end
            end
          end
          default: begin
            d.seq[p] = lps_pkg::SQ_IDLE;
          end
        endcase
      end
      mag = res[p][15] ? 16'(-res[p]) : res[p];
      if (res_valid[p] && mag > lps_pkg::RES_LIM) begin
        fset[lps_pkg::FB_INOC] = 1'b1;
      end
    end
    // Shedding, current limit, reference ramp, once per tick
    tot = {1'b0, cur[0]} + {1'b0, cur[1]};
    mon = two_on ? cur[1] : cur[0];
    lim_act = (q.seq[0] == lps_pkg::SQ_RUN) && mon > lps_pkg::LIMIT_LIM;
    if (tick_now) begin
      d.tot_prev = tot;
      if (q.seq[0] != lps_pkg::SQ_RUN) begin
        d.want2 = 1'b0;
      end else if (tot >= {1'b0, q.shon} ||
                   (tot > q.tot_prev &&
                    tot - q.tot_prev > {1'b0, q.jump})) begin
        d.want2 = 1'b1;
      end else if (tot < {1'b0, q.shoff}) begin
        d.want2 = 1'b0;
      end
      d.bal = two_on && cur[0] > lps_pkg::LIMIT_LIM;
      d.lim = lim_act ? q.lim + 32'd1 : 32'd0;
      if (d.lim >= 32'(LIMIT_TICKS)) begin
        fset[lps_pkg::FB_LIM] = 1'b1;
      end
      if (q.seq[0] != lps_pkg::SQ_RUN || fault_on) begin
        d.vref = '0;
        d.ss_done = 1'b0;
      end else if (!q.ss_done) begin
        d.vref = q.vref + lps_pkg::VREF_STEP;
        if (d.vref >= q.vtgt) begin
          d.vref = q.vtgt;
          d.ss_done = 1'b1;
        end
      end else if (lim_act || prev_act) begin
        d.vref = (q.vref > lps_pkg::VREF_STEP) ?
                 q.vref - lps_pkg::VREF_STEP : 16'h0000;
      end else if (q.vref + lps_pkg::VREF_STEP < q.vtgt) begin
        d.vref = q.vref + lps_pkg::VREF_STEP;
      end else begin
        d.vref = q.vtgt;
      end
    end
    if (ot_trip) begin
      fset[lps_pkg::FB_OT] = 1'b1;
    end
    // Register bus, write
    d.awready = 1'b0;
    d.wready = 1'b0;
    if (awvalid && wvalid && !q.bvalid && !q.awready) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    wr = q.awready && awvalid && wvalid;
    if (wr) begin
      d.bvalid = 1'b1;
      d.bresp = is_map(awaddr) ? lps_pkg::RESP_OK : lps_pkg::RESP_ERR;
      case (awaddr)
        lps_pkg::OFS_CTRL: begin
          wm = wmerge(32'(q.ctrl), wdata, wstrb);
          d.ctrl = wm[2:0];
          clr = wm[lps_pkg::C_CLR];
        end
        lps_pkg::OFS_VTGT: d.vtgt = 16'(wmerge(32'(q.vtgt), wdata, wstrb));
        lps_pkg::OFS_SHON: d.shon = 16'(wmerge(32'(q.shon), wdata, wstrb));
        lps_pkg::OFS_SHOFF: d.shoff = 16'(wmerge(32'(q.shoff), wdata, wstrb));
        lps_pkg::OFS_JUMP: d.jump = 16'(wmerge(32'(q.jump), wdata, wstrb));
        lps_pkg::OFS_PTHR: d.pthr = 16'(wmerge(32'(q.pthr), wdata, wstrb));
        default: d.bresp = d.bresp;
      endcase
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    // Faults: set wins over clear; auto restart unless latched or overtemperature is set
    d.rcnt = '0;
    if (fault_on && !q.ctrl[lps_pkg::C_LATCH] &&
        !q.faults[lps_pkg::FB_OT]) begin
      d.rcnt = tick_now ? q.rcnt + 32'd1 : q.rcnt;
      if (d.rcnt >= 32'(RESTART_TICKS)) begin
        clr = 1'b1;
      end
    end
    d.faults = (clr ? '0 : q.faults) | fset;
    // Register bus, read
    d.arready = 1'b0;
    if (arvalid && !q.rvalid && !q.arready) begin
      d.arready = 1'b1;
    end
    if (q.arready && arvalid) begin
      d.rvalid = 1'b1;
      d.rresp = is_map(araddr) ? lps_pkg::RESP_OK : lps_pkg::RESP_ERR;
      case (araddr)
        lps_pkg::OFS_CTRL: d.rdata = 32'(q.ctrl);
        lps_pkg::OFS_VTGT: d.rdata = 32'(q.vtgt);
        lps_pkg::OFS_SHON: d.rdata = 32'(q.shon);
        lps_pkg::OFS_SHOFF: d.rdata = 32'(q.shoff);
        lps_pkg::OFS_JUMP: d.rdata = 32'(q.jump);
        lps_pkg::OFS_PTHR: d.rdata = 32'(q.pthr);
        lps_pkg::OFS_STAT: d.rdata = 32'({q.bal, q.want2, q.ss_done,
                                           q.seq[1], q.seq[0]});
        lps_pkg::OFS_FLT: d.rdata = 32'(q.faults);
        lps_pkg::OFS_PH0: d.rdata = {{15{q.ph[0][16]}}, q.ph[0]};
        lps_pkg::OFS_PH1: d.rdata = {{15{q.ph[1][16]}}, q.ph[1]};
        lps_pkg::OFS_VREF: d.rdata = 32'(q.vref);
        default: d.rdata = 32'h0000_0000;
      endcase
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= ST_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign low_side_switch = q.ls;
  assign high_side_switch = q.hs;
  assign sync_rectifier = q.sr;
  assign res_sample = q.samp;
  assign vref = q.vref;
  assign bal_to_second = q.bal;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b || !ce);

  a_precharge_low: assert property (
    q.seq[0] == lps_pkg::SQ_PRE_ON |-> q.ls[0] && !q.hs[0])
    else $error("pre-charge drive wrong");
  a_pre_on_len: assert property (
    q.seq[0] == lps_pkg::SQ_PRE_ON &&
    !(|q.faults) && q.ctrl[lps_pkg::C_RUN] &&
    q.tmr[0] == 32'(lps_pkg::PRE_ON_CYC - 1)
    |=> q.seq[0] == lps_pkg::SQ_PRE_OFF && !q.ls[0] && !q.hs[0])
    else $error("pre-charge pulse length wrong");
  a_start_sr_off: assert property (
    q.seq[0] inside {lps_pkg::SQ_PRE_ON, lps_pkg::SQ_PRE_OFF,
                     lps_pkg::SQ_CMP} |-> !q.sr[0])
    else $error("rectifier on during start");
  a_cmp_to_run: assert property (
    q.seq[0] == lps_pkg::SQ_CMP && q.tmr[0] == 32'(START_CYC - 1) &&
    !(|q.faults) && q.ctrl[lps_pkg::C_RUN] && !(q.z2[0] ^ q.z3[0])
    |=> q.seq[0] == lps_pkg::SQ_RUN && q.hp[0] == $past(q.hp[0]))
    else $error("replica handover wrong");
  a_second_follows: assert property (
    q.seq[0] == lps_pkg::SQ_IDLE |=> q.seq[1] == lps_pkg::SQ_IDLE)
    else $error("phase two without phase one");
  a_fast_trip: assert property (
    q.tick == 32'(lps_pkg::TICK_CYC - 1) && q.ss_done &&
    q.seq[0] == lps_pkg::SQ_RUN && !(|q.faults) &&
    q.ctrl[lps_pkg::C_RUN] &&
    i_out0 > lps_pkg::FAST_LIM |=> q.faults[lps_pkg::FB_FAST])
    else $error("fast trip missed");
  a_fault_stops: assert property (
    |q.faults |=> q.seq == '0 && q.hs == 2'b00 && q.ls == 2'b00)
    else $error("fault did not stop switching");
  a_tick_rate: assert property (
    q.tick < 32'(lps_pkg::TICK_CYC - 1) |=> q.tick == $past(q.tick) + 32'd1)
    else $error("tick count step wrong");
  a_tick_wrap: assert property (
    q.tick >= 32'(lps_pkg::TICK_CYC - 1) |=> q.tick == 32'd0)
    else $error("tick period wrong");
  a_cap_detect: assert property (
    q.tick == 32'(lps_pkg::TICK_CYC - 1) && q.seq[0] == lps_pkg::SQ_RUN &&
    !(|q.faults) && q.ctrl[lps_pkg::C_RUN] && q.capz[0] != 2'd0 &&
    $signed(q.ph[0]) <= 17'sd0 |=> q.faults[lps_pkg::FB_CAP])
    else $error("capacitive mode missed");
  a_no_overlap: assert property (
    !(q.hs[0] && q.ls[0]) && !(q.hs[1] && q.ls[1]))
    else $error("both switches on");
endmodule
`default_nettype wire

// >>> tb/lps_stage.sv
// Power stage model: resonant tank comparator output per phase.
// Assumes gate drives from the controller, all on core_clk.
`timescale 1ns/10ps
`default_nettype none
module lps_stage #(
  parameter int HALF = 300
) (
  // Clock
  input wire logic core_clk,
  // Gate drive
  input wire logic [1:0] low_side_switch,
  input wire logic [1:0] high_side_switch,
  // Comparator
  output logic [1:0] zc_pos
);
  int cnt [2];
  initial zc_pos = 2'h0;
  // Tank rings only while a gate drives it
  for (genvar p = 0; p < 2; p++) begin : g_ph
    always @(posedge core_clk) begin
      if (!(low_side_switch[p] | high_side_switch[p])) cnt[p] <= 0;
      else if (cnt[p] == HALF - 1) begin
        cnt[p] <= 0;
        zc_pos[p] <= ~zc_pos[p];
      end else cnt[p] <= cnt[p] + 1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_llc_phase_startup_protection.sv
// Bench: register tasks and start, trip and restart sequences.
// Assumes the stage model closes the zero-crossing loop.
`timescale 1ns/10ps
`default_nettype none
`define CK(a,b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t value mismatch", $time); end end
`define WT(c) begin m = 0; while (!(c) && m < 99) begin \
  @(posedge core_clk); m++; end \
  if (!(c)) begin err_total++; end_of_test(); end end
module test_llc_phase_startup_protection;
  logic core_clk = 0, rst_b = 0, ce = 1, ot_trip = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, bal_to_second;
  logic [1:0] bresp, rresp, r, zc_pos, res_valid = 0, res_sample;
  logic [1:0] low_side_switch, high_side_switch, sync_rectifier;
  logic [15:0] i_out0 = 0, i_out1 = 0, res_cur0 = 0, res_cur1 = 0, vref;
  int err_total = 0, total_checks = 0, n, m;
  always #4 core_clk = ~core_clk;
  lps_ctrl #(.PRE_OFF_CYC(50), .START_CYC(400), .RESTART_TICKS(3),
    .SLOW_TICKS(3), .LIMIT_TICKS(3)) lps_ctrl_i (.*);
  lps_stage lps_stage_i (.*);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    `WT(awready)
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    `WT(bvalid)
    bready <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    `WT(arready)
    arvalid <= 1'h0;
    `WT(rvalid)
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    rd(lps_pkg::OFS_VTGT);
    `CK(d, 32'(lps_pkg::VTGT_RST))
    rd(8'h3c);
    `CK(r, lps_pkg::RESP_ERR)
    $display("registers done");
    wr(lps_pkg::OFS_VTGT, 32'h0000_0010);
    wr(lps_pkg::OFS_CTRL, 32'h0000_0001);
    `WT(low_side_switch[0])
    for (n = 0; low_side_switch[0] && n < 3000; n++) begin
      `CK(high_side_switch[0] | sync_rectifier[0], 1'h0)
      @(posedge core_clk);
    end
    `CK(n, 2500)
    for (n = 0; !high_side_switch[0] && n < 3000; n++) begin
      `CK(low_side_switch[0] | sync_rectifier[0], 1'h0)
      @(posedge core_clk);
    end
    `CK(n, 50)
    for (n = 0; n < 400; n++) begin
      `CK(sync_rectifier[0], 1'h0)
      @(posedge core_clk);
    end
    repeat (20) @(posedge core_clk);
    rd(lps_pkg::OFS_STAT);
    `CK(d[2:0], lps_pkg::SQ_RUN)
    repeat (25000) @(posedge core_clk);
    `CK(vref, 16'h0010)
    $display("start sequence done");
    i_out0 <= 16'h13ec;
    repeat (7500) @(posedge core_clk);
    rd(lps_pkg::OFS_FLT);
    `CK(d[lps_pkg::FB_FAST], 1'h1)
    `CK(low_side_switch | high_side_switch, 2'h0)
    i_out0 <= 16'h0000;
    repeat (12500) @(posedge core_clk);
    rd(lps_pkg::OFS_FLT);
    `CK(d, 32'h0000_0000)
    $display("fast trip and restart done");
    i_out0 <= 16'h0e10;
    repeat (10000) @(posedge core_clk);
    rd(lps_pkg::OFS_FLT);
    `CK(d[lps_pkg::FB_SLOW], 1'h1)
    `CK(d[lps_pkg::FB_FAST], 1'h0)
    i_out0 <= 16'h0000;
    ot_trip <= 1'h1;
    repeat (5000) @(posedge core_clk);
    ot_trip <= 1'h0;
    repeat (12500) @(posedge core_clk);
    rd(lps_pkg::OFS_FLT);
    `CK(d[lps_pkg::FB_OT], 1'h1)
    $display("slow trip and overtemperature done");
    wr(lps_pkg::OFS_VTGT, 32'h0000_0004);
    wr(lps_pkg::OFS_CTRL, 32'h0000_000f);
    repeat (10000) @(posedge core_clk);
    `CK(sync_rectifier[0], 1'h1)
    res_cur0 <= 16'h1000;
    res_valid <= 2'h1;
    repeat (20) @(posedge core_clk);
    res_valid <= 2'h0;
    repeat (8000) @(posedge core_clk);
    rd(lps_pkg::OFS_FLT);
    `CK(d[lps_pkg::FB_INOC], 1'h1)
    `CK(low_side_switch | high_side_switch, 2'h0)
    $display("latching, rectifier and input overcurrent done");
    end_of_test();
  end
endmodule
`default_nettype wire
